// ===== hw/exc_detail_pkg.sv
// Shared constants and types of the exception detail formatter.
package exc_detail_pkg;

    // Register bus geometry.
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Byte offsets of the register map.
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_STATUS     = 8'h04;
    localparam logic [7:0] OFS_MASK       = 8'h08;
    localparam logic [7:0] OFS_COMMON     = 8'h0C;
    localparam logic [7:0] OFS_DEV_ALARM0 = 8'h10;
    localparam logic [7:0] OFS_DEV_ALARM1 = 8'h14;
    localparam logic [7:0] OFS_DEV_WARN0  = 8'h18;
    localparam logic [7:0] OFS_DEV_WARN1  = 8'h1C;
    localparam logic [7:0] OFS_MFR_ALARM  = 8'h20;
    localparam logic [7:0] OFS_MFR_WARN   = 8'h24;

    // Control field positions and reset values.
    localparam int unsigned CTRL_ALARM_EN_BIT = 0;
    localparam int unsigned CTRL_WARN_EN_BIT  = 1;
    localparam logic        ALARM_EN_RST      = 1'b1;
    localparam logic        WARN_EN_RST       = 1'b1;

    // Event status field positions and reset values.
    localparam int unsigned EVT_ALARM_BIT = 0;
    localparam int unsigned EVT_WARN_BIT  = 1;
    localparam logic [1:0]  STATUS_RST    = 2'h0;
    localparam logic [1:0]  MASK_RST      = 2'h0;

    // Size bytes of the detail structures.
    localparam logic [7:0] COMMON_SIZE    = 8'h02;
    localparam logic [7:0] DEV_ALARM_SIZE = 8'h04;
    localparam logic [7:0] DEV_WARN_SIZE  = 8'h05;
    localparam logic [7:0] MFR_SIZE       = 8'h01;

    // Bit positions inside the common detail bytes.
    localparam int unsigned CMN0_DATA_MEM_BIT = 4;
    localparam int unsigned CMN0_NV_MEM_BIT   = 3;
    localparam int unsigned CMN0_CODE_MEM_BIT = 2;
    localparam int unsigned CMN1_SUPPLY_BIT   = 3;

    // Bit positions inside the device and manufacturer bytes.
    localparam int unsigned DEV_ELEC_BIT    = 1;
    localparam int unsigned DEV_FIL2_BIT    = 1;
    localparam int unsigned DEV_FIL1_BIT    = 0;
    localparam int unsigned WRN_INVALID_BIT = 0;
    localparam int unsigned WRN_OVER_BIT    = 1;
    localparam int unsigned WRN_UNDER_BIT   = 2;
    localparam int unsigned WRN_DEGAS_BIT   = 3;
    localparam int unsigned MFR_SERIAL_BIT  = 0;

    // Alarm conditions as raw levels.
    typedef struct packed {
        logic data_mem;
        logic nv_mem;
        logic code_mem;
        logic supply;
        logic tc_elec;
        logic fil2;
        logic fil1;
        logic ion_elec;
        logic serial;
    } alarm_cond_t;

    // Warning conditions as raw levels.
    typedef struct packed {
        logic reading_valid;
        logic overrange;
        logic underrange;
        logic tc_elec;
        logic fil2;
        logic fil1;
        logic degas_press;
        logic serial;
    } warn_cond_t;

    // Assembled detail bytes, sizes excluded.
    typedef struct packed {
        logic [1:0][7:0] common;
        logic [3:0][7:0] dev_alarm;
        logic [4:0][7:0] dev_warn;
        logic [7:0]      mfr_alarm;
        logic [7:0]      mfr_warn;
    } detail_t;

endpackage : exc_detail_pkg

// ===== hw/detail_if.sv
// Carrier of the assembled detail bytes between builder and bus slave.
`timescale 1ns/1ps
interface detail_if;
    import exc_detail_pkg::*;

    // Registered detail bytes.
    detail_t detail;

    // Builder drives the bytes.
    modport builder (output detail);
    // Slave only reads them.
    modport reader (input detail);
endinterface : detail_if

// ===== hw/detail_builder.sv
// Packs fault and warning conditions into the detail byte arrays.
`timescale 1ns/1ps
module detail_builder (
    // Clock and reset.
    input  wire logic                        clock_i,
    input  wire logic                        nrst_i,
    // Conditions and enables.
    input  wire exc_detail_pkg::alarm_cond_t alarm_i,
    input  wire exc_detail_pkg::warn_cond_t  warn_i,
    input  wire logic                        alarm_en_i,
    input  wire logic                        warn_en_i,
    // Assembled bytes.
    detail_if.builder                        out
);
    import exc_detail_pkg::*;

    // Whole state of the builder.
    detail_t detail_r;
    detail_t detail_nxt;

    // Rebuilds every byte from the present conditions each cycle.
    always_comb begin
        // (RULE_09) unused bits zero
        detail_nxt = '0;
        // (RULE_11) alarm enable gating
        if (alarm_en_i) begin
            // (RULE_02) memory fault bits
            detail_nxt.common[0][CMN0_DATA_MEM_BIT] = alarm_i.data_mem;
            detail_nxt.common[0][CMN0_NV_MEM_BIT]   = alarm_i.nv_mem;
            detail_nxt.common[0][CMN0_CODE_MEM_BIT] = alarm_i.code_mem;
            // (RULE_03) supply voltage bit
            detail_nxt.common[1][CMN1_SUPPLY_BIT]   = alarm_i.supply;
            // (RULE_05) device alarm bytes
            detail_nxt.dev_alarm[1][DEV_ELEC_BIT]   = alarm_i.tc_elec;
            detail_nxt.dev_alarm[2][DEV_FIL2_BIT]   = alarm_i.fil2;
            detail_nxt.dev_alarm[2][DEV_FIL1_BIT]   = alarm_i.fil1;
            detail_nxt.dev_alarm[3][DEV_ELEC_BIT]   = alarm_i.ion_elec;
            // (RULE_07) serial failure bit
            detail_nxt.mfr_alarm[MFR_SERIAL_BIT]    = alarm_i.serial;
        end
        // (RULE_11) warning enable gating
        if (warn_en_i) begin
            // (RULE_10) sensor status extension
            detail_nxt.dev_warn[0][WRN_INVALID_BIT] = ~warn_i.reading_valid;
            detail_nxt.dev_warn[0][WRN_OVER_BIT]    = warn_i.overrange;
            detail_nxt.dev_warn[0][WRN_UNDER_BIT]   = warn_i.underrange;
            detail_nxt.dev_warn[2][DEV_ELEC_BIT]    = warn_i.tc_elec;
            detail_nxt.dev_warn[3][DEV_FIL2_BIT]    = warn_i.fil2;
            detail_nxt.dev_warn[3][DEV_FIL1_BIT]    = warn_i.fil1;
            detail_nxt.dev_warn[4][WRN_DEGAS_BIT]   = warn_i.degas_press;
            detail_nxt.mfr_warn[MFR_SERIAL_BIT]     = warn_i.serial;
        end
    end

    // Registers the bytes; nothing is latched beyond one cycle.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            detail_r <= '0;
        end else begin
            detail_r <= detail_nxt;
        end
    end

    // The bytes leave straight from the register.
    assign out.detail = detail_r;

endmodule : detail_builder

// ===== hw/exception_detail_formatter.sv
// Avalon-MM slave that reports the gauge exception detail structures.
//
// Behaviour
// (RULE_01) Common detail size byte equals two.
// (RULE_02) Common byte zero: data, nonvolatile, code memory.
// (RULE_03) Common byte one bit three: supply voltage.
// (RULE_04) Device size four for alarms, five warnings.
// (RULE_05) Device alarm bytes carry electronics and filament faults.
// (RULE_06) Manufacturer detail is one byte, size one.
// (RULE_07) Manufacturer bit zero flags serial failure.
// (RULE_08) Size byte precedes array of that length.
// (RULE_09) Unassigned detail bits always read zero.
// (RULE_10) Warning byte zero: invalid, overrange, underrange.
// (RULE_11) Enables gate bits; disabling clears; no latching.
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
module exception_detail_formatter (
    // Clock and reset.
    input  wire logic                                clock_i,
    input  wire logic                                nrst_i,
    // Avalon-MM slave port.
    input  wire logic [exc_detail_pkg::ADDR_W-1:0]   address_i,
    input  wire logic                                read_i,
    input  wire logic                                write_i,
    input  wire logic [exc_detail_pkg::DATA_W-1:0]   writedata_i,
    input  wire logic [3:0]                          byteenable_i,
    output logic      [exc_detail_pkg::DATA_W-1:0]   readdata_o,
    output logic                                     waitrequest_o,
    // Alarm conditions.
    input  wire logic                                data_mem_fault_i,
    input  wire logic                                nv_mem_fault_i,
    input  wire logic                                code_mem_fault_i,
    input  wire logic                                supply_fault_i,
    input  wire logic                                tc_elec_fail_i,
    input  wire logic                                fil1_fail_i,
    input  wire logic                                fil2_fail_i,
    input  wire logic                                ion_elec_fail_i,
    input  wire logic                                serial_fail_i,
    // Warning conditions.
    input  wire logic                                reading_valid_i,
    input  wire logic                                overrange_i,
    input  wire logic                                underrange_i,
    input  wire logic                                tc_elec_warn_i,
    input  wire logic                                fil1_warn_i,
    input  wire logic                                fil2_warn_i,
    input  wire logic                                degas_press_warn_i,
    input  wire logic                                serial_warn_i,
    // Interrupt.
    output logic                                     irq_o
);
    import exc_detail_pkg::*;

    // Whole state of the bus slave and event logic.
    typedef struct packed {
        logic              waitreq;    // Stall flag seen by the master.
        logic [DATA_W-1:0] rdata;      // Read data held for the master.
        logic              alarm_en;   // Alarm reporting enable.
        logic              warn_en;    // Warning reporting enable.
        logic [1:0]        status;     // Sticky event bits.
        logic [1:0]        mask;       // Interrupt mask, one enables.
        logic              irq;        // Registered interrupt level.
        logic              alarm_prev; // Alarm summary of last cycle.
        logic              warn_prev;  // Warning summary of last cycle.
    } slave_state_t;

    // Current and next state.
    slave_state_t st_r;
    slave_state_t st_nxt;

    // Condition bundles handed to the builder.
    alarm_cond_t alarm_cond;
    warn_cond_t  warn_cond;

    // Detail bytes coming back from the builder.
    detail_if det ();

    // Summaries of active, enabled conditions.
    logic alarm_any;
    logic warn_any;

    // Bus handshake terms.
    logic req;        // A read or write is being presented.
    logic first_seen; // First cycle of a request: data are prepared.
    logic commit;     // Cycle in which the master takes the answer.

    // Compares a word address against a register offset.
    function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0]        ofs);
        addr_is = (addr[ADDR_W-1:2] == ofs[7:2]);
    endfunction : addr_is

    // Merges write data into a narrow field under byte lane zero.
    function automatic logic [1:0] lane0_merge(
        input logic [1:0] old,
        input logic [1:0] wdat,
        input logic       be0);
        lane0_merge = be0 ? wdat : old;
    endfunction : lane0_merge

    // Gathers the alarm inputs into one bundle.
    assign alarm_cond = {
        data_mem_fault_i,
        nv_mem_fault_i,
        code_mem_fault_i,
        supply_fault_i,
        tc_elec_fail_i,
        fil2_fail_i,
        fil1_fail_i,
        ion_elec_fail_i,
        serial_fail_i
    };

    // Gathers the warning inputs into one bundle.
    assign warn_cond = {
        reading_valid_i,
        overrange_i,
        underrange_i,
        tc_elec_warn_i,
        fil2_warn_i,
        fil1_warn_i,
        degas_press_warn_i,
        serial_warn_i
    };

    // Byte builder; it sees the enables held in the control register.
    detail_builder u_builder (
        .clock_i    (clock_i),
        .nrst_i     (nrst_i),
        .alarm_i    (alarm_cond),
        .warn_i     (warn_cond),
        .alarm_en_i (st_r.alarm_en),
        .warn_en_i  (st_r.warn_en),
        .out        (det.builder)
    );

    // Any set alarm or warning bit counts as an active condition.
    assign alarm_any = (|det.detail.common) | (|det.detail.dev_alarm)
                     | (|det.detail.mfr_alarm);
    assign warn_any  = (|det.detail.dev_warn) | (|det.detail.mfr_warn);

    // A request waits exactly one cycle before it is answered.
    assign req        = read_i | write_i;
    assign first_seen = req & st_r.waitreq;
    assign commit     = req & ~st_r.waitreq;

    // Selects the word a read returns; unmapped offsets read zero.
    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] addr,
        input slave_state_t      s,
        input detail_t           d);
        read_word = '0;
        if (addr_is(addr, OFS_CTRL)) begin
            read_word[CTRL_ALARM_EN_BIT] = s.alarm_en;
            read_word[CTRL_WARN_EN_BIT]  = s.warn_en;
        end else if (addr_is(addr, OFS_STATUS)) begin
            read_word[1:0] = s.status;
        end else if (addr_is(addr, OFS_MASK)) begin
            read_word[1:0] = s.mask;
        end else if (addr_is(addr, OFS_COMMON)) begin
            // (RULE_01) common size two
            read_word[23:0] = {d.common[1], d.common[0], COMMON_SIZE};
        end else if (addr_is(addr, OFS_DEV_ALARM0)) begin
            // (RULE_04) alarm size four
            read_word = {d.dev_alarm[2], d.dev_alarm[1], d.dev_alarm[0],
                         DEV_ALARM_SIZE};
        end else if (addr_is(addr, OFS_DEV_ALARM1)) begin
            read_word[7:0] = d.dev_alarm[3];
        end else if (addr_is(addr, OFS_DEV_WARN0)) begin
            // (RULE_04) warning size five
            read_word = {d.dev_warn[2], d.dev_warn[1], d.dev_warn[0],
                         DEV_WARN_SIZE};
        end else if (addr_is(addr, OFS_DEV_WARN1)) begin
            read_word[15:0] = {d.dev_warn[4], d.dev_warn[3]};
        end else if (addr_is(addr, OFS_MFR_ALARM)) begin
            // (RULE_06) manufacturer size one
            read_word[15:0] = {d.mfr_alarm, MFR_SIZE};
        end else if (addr_is(addr, OFS_MFR_WARN)) begin
            // (RULE_08) size then array
            read_word[15:0] = {d.mfr_warn, MFR_SIZE};
        end
    endfunction : read_word

    // Next-state logic of handshake, registers, events and interrupt.
    always_comb begin
        st_nxt = st_r;

        // Raise the stall again after each answered request.
        st_nxt.waitreq = ~first_seen;

        // Read data are captured one edge before the master takes them.
        if (first_seen && read_i) begin
            st_nxt.rdata = read_word(address_i, st_r, det.detail);
        end

        // Register writes take effect only at the answering edge.
        if (commit && write_i) begin
            if (addr_is(address_i, OFS_CTRL) && byteenable_i[0]) begin
                // (RULE_11) enable attributes written
                st_nxt.alarm_en = writedata_i[CTRL_ALARM_EN_BIT];
                st_nxt.warn_en  = writedata_i[CTRL_WARN_EN_BIT];
            end else if (addr_is(address_i, OFS_STATUS) && byteenable_i[0]) begin
                // Write one to clear.
                st_nxt.status = st_r.status & ~writedata_i[1:0];
            end else if (addr_is(address_i, OFS_MASK)) begin
                st_nxt.mask = lane0_merge(st_r.mask, writedata_i[1:0], byteenable_i[0]);
            end
        end

        // Remember the summaries to find their rising edges.
        st_nxt.alarm_prev = alarm_any;
        st_nxt.warn_prev  = warn_any;

        // Rising summaries set their sticky bits; a set beats a clear.
        if (alarm_any && !st_r.alarm_prev) begin
            st_nxt.status[EVT_ALARM_BIT] = 1'b1;
        end
        if (warn_any && !st_r.warn_prev) begin
            st_nxt.status[EVT_WARN_BIT] = 1'b1;
        end

        // Interrupt follows the masked status of the next cycle.
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    // State register with asynchronous reset to constants.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r.waitreq    <= 1'b1;
            st_r.rdata      <= '0;
            st_r.alarm_en   <= ALARM_EN_RST;
            st_r.warn_en    <= WARN_EN_RST;
            st_r.status     <= STATUS_RST;
            st_r.mask       <= MASK_RST;
            st_r.irq        <= 1'b0;
            st_r.alarm_prev <= 1'b0;
            st_r.warn_prev  <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign readdata_o    = st_r.rdata;
    assign waitrequest_o = st_r.waitreq;
    assign irq_o         = st_r.irq;

endmodule : exception_detail_formatter

// ===== verification/avalon_master_model.sv
// Avalon-MM master model standing in for the fieldbus side of the block.
`timescale 1ns/1ps
module avalon_master_model (
    // Clock and reset.
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    // Command from the bench.
    input  wire logic        start_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  be_i,
    output logic             done_o,
    output logic [31:0]      rdata_o,
    // Bus toward the slave.
    output logic [7:0]       address_o,
    output logic             read_o,
    output logic             write_o,
    output logic [31:0]      writedata_o,
    output logic [3:0]       byteenable_o,
    input  wire logic [31:0] readdata_i,
    input  wire logic        waitrequest_i
);
    // Holds a request until waitrequest is sampled low, then takes the answer.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {read_o, write_o, done_o, address_o, writedata_o, byteenable_o, rdata_o} <= '0;
        end else begin
            done_o <= 1'b0;
            if ((read_o || write_o) && !waitrequest_i) begin
                // Released address and write data lines show the inverse so stale values are never trusted.
                rdata_o     <= readdata_i;
                read_o      <= 1'b0;
                write_o     <= 1'b0;
                done_o      <= 1'b1;
                address_o   <= ~address_o;
                writedata_o <= ~writedata_o;
            end else if (start_i && !read_o && !write_o) begin
                address_o    <= addr_i;
                writedata_o  <= wdata_i;
                byteenable_o <= be_i;
                read_o       <= !wr_i;
                write_o      <= wr_i;
            end
        end
    end
endmodule : avalon_master_model

// ===== verification/exception_detail_formatter_chk.sv
// Port-level assertions of the exception detail formatter.
`timescale 1ns/1ps
module exception_detail_formatter_chk
    import exc_detail_pkg::*;
(
    // Clock and reset.
    input wire logic              clock_i,
    input wire logic              nrst_i,
    // Bus and interrupt.
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic              read_i,
    input wire logic              write_i,
    input wire logic [DATA_W-1:0] readdata_o,
    input wire logic              waitrequest_o,
    input wire logic              irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    // A read answer being taken, and the word it addresses.
    logic       rd_ack;
    logic [5:0] word;
    assign rd_ack = read_i && !waitrequest_o;
    assign word   = address_i[7:2];

    wait_one_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("no answer after one wait");
    wait_pulse_a: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low too long");
    idle_wait_a: assert property (!read_i && !write_i && waitrequest_o |=> waitrequest_o)
        else $error("answer without request");
    common_fmt_a: assert property (rd_ack && word == OFS_COMMON[7:2] |->
        readdata_o[7:0] == COMMON_SIZE && (readdata_o & 32'hFFF7_E300) == 32'h0)
        else $error("bad common word");
    dev_alarm_fmt_a: assert property (rd_ack && word == OFS_DEV_ALARM0[7:2] |->
        readdata_o[7:0] == 8'h04 && (readdata_o & 32'hFCFD_FF00) == 32'h0)
        else $error("bad device alarm word");
    dev_warn_fmt_a: assert property (rd_ack && word == OFS_DEV_WARN0[7:2] |->
        readdata_o[7:0] == 8'h05 && (readdata_o & 32'hFDFF_F800) == 32'h0)
        else $error("bad device warning word");
    mfr_fmt_a: assert property (rd_ack && word >= OFS_MFR_ALARM[7:2] && word <= 6'h09 |->
        readdata_o[7:0] == MFR_SIZE && (readdata_o & 32'hFFFF_FE00) == 32'h0)
        else $error("bad manufacturer word");
    unmapped_zero_a: assert property (rd_ack && word > 6'h09 |-> readdata_o == 32'h0)
        else $error("unmapped read not zero");

    common_read_c: cover property (rd_ack && word == OFS_COMMON[7:2]);
    irq_rise_c: cover property ($rose(irq_o));
    write_done_c: cover property (write_i && !waitrequest_o);
endmodule : exception_detail_formatter_chk

bind exception_detail_formatter exception_detail_formatter_chk u_chk (
    .clock_i, .nrst_i, .address_i, .read_i, .write_i, .readdata_o, .waitrequest_o, .irq_o);

// ===== verification/exception_detail_formatter_tb.sv
// Self-checking bench of the exception detail formatter.
`timescale 1ns/1ps
module exception_detail_formatter_tb;
    import exc_detail_pkg::*;

    // Clock, reset, master command and bus wires.
    logic        clock_i, nrst_i, start, wr, done, read, write, waitrequest, irq;
    logic [3:0]  be, byteenable;
    logic [7:0]  addr, address;
    logic [31:0] wdat, rdata, writedata, readdata, seed;
    // Conditions and the bench's view of the control state.
    logic [16:0] cond;
    logic        aen, wen;
    logic [1:0]  mask, stat;
    int          miscompares, comparisons, cycles;

    avalon_master_model far_end (
        .clock_i, .nrst_i, .start_i(start), .wr_i(wr), .addr_i(addr),
        .wdata_i(wdat), .be_i(be), .done_o(done), .rdata_o(rdata), .address_o(address),
        .read_o(read), .write_o(write), .writedata_o(writedata), .byteenable_o(byteenable),
        .readdata_i(readdata), .waitrequest_i(waitrequest));

    exception_detail_formatter DUT (
        .clock_i, .nrst_i, .address_i(address), .read_i(read),
        .write_i(write), .writedata_i(writedata), .byteenable_i(byteenable),
        .readdata_o(readdata), .waitrequest_o(waitrequest), .irq_o(irq),
        .data_mem_fault_i(cond[0]), .nv_mem_fault_i(cond[1]), .code_mem_fault_i(cond[2]),
        .supply_fault_i(cond[3]), .tc_elec_fail_i(cond[4]), .fil1_fail_i(cond[5]),
        .fil2_fail_i(cond[6]), .ion_elec_fail_i(cond[7]), .serial_fail_i(cond[8]),
        .reading_valid_i(cond[9]), .overrange_i(cond[10]), .underrange_i(cond[11]),
        .tc_elec_warn_i(cond[12]), .fil1_warn_i(cond[13]), .fil2_warn_i(cond[14]),
        .degas_press_warn_i(cond[15]), .serial_warn_i(cond[16]));

    // Free-running 250 MHz clock.
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // Xorshift source of random stimulus.
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Reference word of each address, gated by the enables as conditions stand now.
    function automatic logic [31:0] model(input logic [7:0] a);
        logic [8:0] al;
        logic [7:0] w;
        al = cond[8:0] & {9{aen}};
        w  = {cond[16:10], ~cond[9]} & {8{wen}};
        case (a)
            OFS_CTRL:       return {30'h0, wen, aen};
            OFS_STATUS:     return {30'h0, stat};
            OFS_MASK:       return {30'h0, mask};
            OFS_COMMON:     return {12'h0, al[3], 6'h0, al[0], al[1], al[2], 10'h002};
            OFS_DEV_ALARM0: return {6'h0, al[6], al[5], 6'h0, al[4], 17'h0_0004};
            OFS_DEV_ALARM1: return {30'h0, al[7], 1'b0};
            OFS_DEV_WARN0:  return {6'h0, w[3], 14'h0, w[2:0], 8'h05};
            OFS_DEV_WARN1:  return {20'h0, w[6], 9'h0, w[5:4]};
            OFS_MFR_ALARM:  return {23'h0, al[8], 8'h01};
            OFS_MFR_WARN:   return {23'h0, w[7], 8'h01};
            default:        return 32'h0;
        endcase
    endfunction : model

    // Counts one comparison and reports a difference.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One bus transfer through the master model, waiting for its answer.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge clock_i);
        start <= 1'b1;
        wr    <= w;
        addr  <= a;
        wdat  <= d;
        be    <= b;
        @(posedge clock_i);
        start <= 1'b0;
        @(negedge clock_i);
        for (int n = 0; n < 40 && done !== 1'b1; n++) @(negedge clock_i);
        if (done !== 1'b1) miscompares++;
    endtask : bus

    // Reads one word and compares it with the reference.
    task automatic rdchk(input logic [7:0] a);
        bus(1'b0, a, 32'h0, 4'hF);
        chk($sformatf("word %h", a), model(a), rdata);
    endtask : rdchk

    // Lets the interrupt settle, then compares it.
    task automatic irq_chk(input logic e);
        repeat (4) @(negedge clock_i);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irq_chk

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // Cuts a hang short.
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        nrst_i = 1'b0;
        {start, wr, addr, wdat, be} = '0;
        cond   = 17'h0_0200;
        seed   = 32'h0000_91F9;
        {aen, wen, mask, stat} = 6'h30;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        // Random conditions and enables; every word but status read back, unmapped one included.
        for (int k = 0; k < 24; k++) begin
            void'(xs());
            bus(1'b1, OFS_CTRL, {30'h0, seed[18:17]}, 4'h1);
            {wen, aen} = seed[18:17];
            @(posedge clock_i);
            cond <= seed[16:0];
            repeat (3) @(posedge clock_i);
            for (int i = 0; i < 11; i++) begin
                if (i != 1) rdchk(8'(i * 4));
            end
        end
        // A write with lane zero disabled leaves control alone.
        bus(1'b1, OFS_CTRL, 32'h0, 4'hE);
        rdchk(OFS_CTRL);
        bus(1'b1, OFS_CTRL, 32'h3, 4'h1);
        {aen, wen} = 2'h3;
        @(posedge clock_i);
        cond <= 17'h0_0200;
        bus(1'b1, OFS_MASK, 32'h1, 4'h1);
        mask = 2'h1;
        bus(1'b1, OFS_STATUS, 32'h3, 4'h1);
        stat = 2'h0;
        irq_chk(1'b0);
        // An alarm edge sets status bit zero and raises the interrupt.
        @(posedge clock_i);
        cond[4] <= 1'b1;
        stat = 2'h1;
        irq_chk(1'b1);
        rdchk(OFS_STATUS);
        bus(1'b1, OFS_STATUS, 32'h1, 4'h1);
        stat = 2'h0;
        irq_chk(1'b0);
        // A warning edge while masked sets bit one only.
        @(posedge clock_i);
        cond[11] <= 1'b1;
        stat = 2'h2;
        irq_chk(1'b0);
        rdchk(OFS_STATUS);
        rdchk(OFS_DEV_WARN0);
        bus(1'b1, OFS_MASK, 32'h3, 4'h1);
        mask = 2'h3;
        irq_chk(1'b1);
        // Held conditions bring no new event once cleared.
        bus(1'b1, OFS_STATUS, 32'h3, 4'h1);
        stat = 2'h0;
        irq_chk(1'b0);
        // Disabling alarms clears their bits but keeps the sizes.
        bus(1'b1, OFS_CTRL, 32'h2, 4'h1);
        aen = 1'b0;
        rdchk(OFS_DEV_ALARM0);
        bus(1'b1, 8'h3C, 32'hFFFF_FFFF, 4'hF);
        rdchk(8'h3C);
        // A second reset in mid-run restores the defaults.
        @(posedge clock_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        {aen, wen, mask, stat} = 6'h30;
        rdchk(OFS_CTRL);
        rdchk(OFS_MASK);
        give_verdict();
    end
endmodule : exception_detail_formatter_tb
